/* inc/tss_pkg.sv */
// ==========================================================
// time-slot switch constants
package tss_pkg;
  // stream and memory geometry
  localparam int NSTR = 8;
  localparam int DM_AW = 9;
  localparam int CM_AW = 8;
  // channels per frame at each rate
  localparam int CH_LOW = 32;
  localparam int CH_MID = 64;
  localparam int CH_HIGH = 128;
  // rate field codes
  localparam logic [1:0] RATE_2M = 2'h0;
  localparam logic [1:0] RATE_4M = 2'h1;
  localparam logic [1:0] RATE_8M = 2'h2;
  // switch config codes
  localparam logic [1:0] SCB_8X8 = 2'h0;
  localparam logic [1:0] SCB_16X8 = 2'h1;
  localparam logic [1:0] SCB_PAIR = 2'h2;
  // register offsets, bit 5 opens the memory window
  localparam logic [5:0] REG_CTRL = 6'h00;
  localparam logic [5:0] REG_IMS = 6'h01;
  localparam logic [5:0] REG_STAT = 6'h02;
  localparam int MEM_WIN_BIT = 5;
  // control register fields
  localparam int CTRL_MSEL_LSB = 0;
  localparam int CTRL_PAGE_LSB = 2;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [1:0] MSEL_DM = 2'h0;
  localparam logic [1:0] MSEL_CML = 2'h1;
  localparam logic [1:0] MSEL_CMH = 2'h2;
  // interface mode select fields
  localparam int IMS_DMO = 0;
  localparam int IMS_IDR_LSB = 1;
  localparam int IMS_ODR_LSB = 3;
  localparam int IMS_SCB_LSB = 5;
  localparam int IMS_CLOCK_MODE_BIT = 7;
  localparam logic [7:0] IMS_RST = 8'h00;
  // connect memory high fields
  localparam int CMH_OE = 0;
  localparam int CMH_MSG = 1;
  localparam int CMH_CDLY = 2;
  localparam int CMH_CSO = 3;
  localparam logic [7:0] CMH_RST = 8'h00;
  // frame pulse: a level lasting fewer link clock rising edges than this is the pulse
  localparam logic [3:0] FP_SHORT = 4'h8;
endpackage : tss_pkg

/* inc/tss_timing_if.sv */
`timescale 1ns/1ps
// ==========================================================
// link edge and frame format signals
interface tss_timing_if;
  logic lclk_rise;
  logic lclk_fall;
  logic fp_now;
  logic pol_pos;
  logic fmt_valid;
  modport src (output lclk_rise, output lclk_fall, output fp_now, output pol_pos, output fmt_valid);
  modport snk (input lclk_rise, input lclk_fall, input fp_now, input pol_pos, input fmt_valid);
endinterface : tss_timing_if

/* core/tss_frame_det.sv */
`timescale 1ns/1ps
// ==========================================================
// link clock edges and frame pulse format detection
module tss_frame_det import tss_pkg::*; (
  // system
  input wire logic clk,
  input wire logic srst,
  // link pins
  input wire logic link_clk,
  input wire logic frame_pulse,
  // timing out
  tss_timing_if.src tif
);
  logic lclk_d;
  logic fp_ref;
  logic [3:0] run_cnt;

  // edge pulses and sampled pulse
  always_ff @(posedge clk) begin
    if (srst) begin
      lclk_d <= 1'b0;
      tif.lclk_rise <= 1'b0;
      tif.lclk_fall <= 1'b0;
      tif.fp_now <= 1'b0;
    end else begin
      lclk_d <= link_clk;
      tif.lclk_rise <= link_clk & ~lclk_d;
      tif.lclk_fall <= ~link_clk & lclk_d;
      tif.fp_now <= frame_pulse;
    end
  end

  // short level run names the pulse polarity
  always_ff @(posedge clk) begin
    if (srst) begin
      fp_ref <= 1'b1;
      run_cnt <= 4'hf;
      tif.pol_pos <= 1'b0;
      tif.fmt_valid <= 1'b0;
    end else if (tif.lclk_rise) begin
      if (tif.fp_now != fp_ref) begin
        if (run_cnt < FP_SHORT) begin
          tif.pol_pos <= fp_ref;
          tif.fmt_valid <= 1'b1;
        end
        fp_ref <= tif.fp_now;
        run_cnt <= 4'h1;
      end else if (run_cnt != 4'hf) begin
        run_cnt <= run_cnt + 4'h1;
      end
    end
  end
endmodule : tss_frame_det

/* core/tss_bit_timer.sv */
`timescale 1ns/1ps
// ==========================================================
// per-direction bit timing from link edges
module tss_bit_timer import tss_pkg::*; (
  // system
  input wire logic clk,
  input wire logic srst,
  // timing in
  tss_timing_if.snk tif,
  // configuration
  input wire logic [1:0] cpb_log,
  input wire logic [1:0] rate,
  // ticks
  output logic tick_bound,
  output logic tick_samp,
  output logic frame_start,
  output logic [9:0] bitpos
);
  logic [1:0] sub;
  logic fp_last;
  wire [1:0] sub_last = (cpb_log == 2'h2) ? 2'h3 : ((cpb_log == 2'h1) ? 2'h1 : 2'h0);
  wire [9:0] bit_last = (rate == RATE_8M) ? 10'h3ff : ((rate == RATE_4M) ? 10'h1ff : 10'h0ff);
  // boundary edge follows polarity: positive/gci rising, negative/native falling
  wire bedge = tif.fmt_valid & (tif.pol_pos ? tif.lclk_rise : tif.lclk_fall);
  wire sedge = tif.fmt_valid & (tif.pol_pos ? tif.lclk_fall : tif.lclk_rise);
  wire fp_lead = (tif.fp_now == tif.pol_pos) & (fp_last != tif.pol_pos);

  // sub-bit and bit counters, restarted by the frame pulse
  always_ff @(posedge clk) begin
    if (srst) begin
      sub <= 2'h0;
      bitpos <= 10'h000;
      fp_last <= 1'b0;
      frame_start <= 1'b0;
      tick_bound <= 1'b0;
    end else begin
      frame_start <= 1'b0;
      tick_bound <= 1'b0;
      if (bedge) begin
        fp_last <= tif.fp_now;
        if (fp_lead) begin
          sub <= 2'h0;
          bitpos <= 10'h000;
          frame_start <= 1'b1;
          tick_bound <= 1'b1;
        end else if (sub == sub_last) begin
          sub <= 2'h0;
          bitpos <= (bitpos == bit_last) ? 10'h000 : bitpos + 10'h001;
          tick_bound <= 1'b1;
        end else begin
          sub <= sub + 2'h1;
        end
      end
    end
  end

  // sample on the opposite edge in the last clock of the bit (three quarters in at two link clocks per bit)
  always_ff @(posedge clk) begin
    if (srst) begin
      tick_samp <= 1'b0;
    end else begin
      tick_samp <= sedge & (sub == sub_last);
    end
  end
endmodule : tss_bit_timer

/* core/tss_core.sv */
`timescale 1ns/1ps
// ==========================================================
// Contract
// - frames hold 32, 64 or 128 channels
// - every input byte written sequentially to data memory
// - frame pulse restarts write address counter
// - next output byte fetched in previous slot
// - connection mode sends addressed data memory byte
// - many outputs may share one source
// - message byte repeats every frame until rewritten
// - high memory picks mode, delay, driver enable
// - high memory bit drives control serial output
// - disabled channel floats only in its slot
// - drive enable low floats every output; control serial output has no enable and stays driven
// - upper address from control, lower from pins
// - input and output rates chosen independently
// - config field sets streams when rates match at 2 or 4 Mb/s
// - clock mode bit: twice or equal rate; code applies it only at matched 2 Mb/s, other modes fix clocks per bit
// - detect frame pulse format, set edges
// - native: falling boundary, rising sample late
// - gci: rising boundary, falling sample late
// - fast links: edges follow pulse polarity
// - mixed rates: each side keeps own edges
module tss_core import tss_pkg::*; (
  // system
  input wire logic clk,
  input wire logic srst,
  // link timing pins
  input wire logic link_clk,
  input wire logic frame_pulse,
  input wire logic output_drive_enable,
  // serial streams
  input wire logic [NSTR-1:0] serial_in,
  output logic [NSTR-1:0] serial_out,
  output logic [NSTR-1:0] serial_out_oe_n,
  output logic control_serial_out,
  // cpu register port
  input wire logic [5:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata
);
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_RUN} tss_seq_t;

  // ==========================================================
  // storage
  logic [7:0] data_mem [0:(1<<DM_AW)-1];
  logic [7:0] conn_mem_low [0:(1<<CM_AW)-1];
  logic [7:0] conn_mem_high [0:(1<<CM_AW)-1];
  logic [7:0] ctrl;
  logic [7:0] interface_mode_select_reg;
  logic wbank;

  // ==========================================================
  // mode decode
  wire main_operation_bit = interface_mode_select_reg[IMS_DMO];
  wire [1:0] input_rate_field = interface_mode_select_reg[IMS_IDR_LSB +: 2];
  wire [1:0] output_rate_field = interface_mode_select_reg[IMS_ODR_LSB +: 2];
  wire [1:0] switch_config_field = interface_mode_select_reg[IMS_SCB_LSB +: 2];
  wire clock_mode_bit = interface_mode_select_reg[IMS_CLOCK_MODE_BIT];

  // identical rates ignore the output field
  wire [1:0] irate = input_rate_field;
  wire [1:0] orate = main_operation_bit ? output_rate_field : input_rate_field;
  wire fast_clk = (irate == RATE_8M) | (orate == RATE_8M);
  wire [1:0] clk_code = fast_clk ? 2'h2 : 2'h1;

  // clocks per bit, as a power of two
  wire [1:0] same_cpb = ((irate == RATE_2M) & ~clock_mode_bit) ? 2'h1 : 2'h0;
  wire [1:0] in_cpb = main_operation_bit ? clk_code - irate : same_cpb;
  wire [1:0] out_cpb = main_operation_bit ? clk_code - orate : same_cpb;

  // active stream counts
  logic [3:0] in_n;
  logic [3:0] out_n;
  always_comb begin
    in_n = 4'h8 >> irate;
    out_n = 4'h8 >> orate;
    if (!main_operation_bit) begin
      if (irate == RATE_2M) begin
        in_n = (switch_config_field == SCB_PAIR) ? 4'h4 : 4'h8;
        out_n = (switch_config_field == SCB_8X8 || switch_config_field == SCB_16X8) ? 4'h8 : 4'h4;
      end else if (irate == RATE_4M) begin
        in_n = (switch_config_field == SCB_8X8) ? 4'h8 : 4'h4;
        out_n = 4'h4;
      end
    end
  end

  // stream and channel packed into one memory index
  function automatic logic [7:0] chan_idx(input logic [1:0] rate, input logic [2:0] s, input logic [6:0] ch);
    case (rate)
      RATE_4M: chan_idx = {s[1:0], ch[5:0]};
      RATE_8M: chan_idx = {s[0], ch[6:0]};
      default: chan_idx = {s, ch[4:0]};
    endcase
  endfunction : chan_idx

  // ==========================================================
  // link timing
  tss_timing_if tif ();
  logic in_bound;
  logic in_samp;
  logic in_fstart;
  logic [9:0] in_pos;
  logic out_bound;
  logic out_fstart;
  logic [9:0] out_pos;

  tss_frame_det u_det (
    .clk(clk),
    .srst(srst),
    .link_clk(link_clk),
    .frame_pulse(frame_pulse),
    .tif(tif.src)
  );

  tss_bit_timer u_in_tmr (
    .clk(clk),
    .srst(srst),
    .tif(tif.snk),
    .cpb_log(in_cpb),
    .rate(irate),
    .tick_bound(in_bound),
    .tick_samp(in_samp),
    .frame_start(in_fstart),
    .bitpos(in_pos)
  );

  tss_bit_timer u_out_tmr (
    .clk(clk),
    .srst(srst),
    .tif(tif.snk),
    .cpb_log(out_cpb),
    .rate(orate),
    .tick_bound(out_bound),
    .tick_samp(),
    .frame_start(out_fstart),
    .bitpos(out_pos)
  );

  // ==========================================================
  // receive: deserialise and write in sequence
  logic [7:0] in_sh [0:NSTR-1];
  logic [7:0] in_buf [0:NSTR-1];
  logic [6:0] wr_ch;
  logic [3:0] wcnt;
  logic wr_bank;
  tss_seq_t wstate;
  wire byte_done = in_samp & (in_pos[2:0] == 3'h7);

  genvar gi;
  generate
    for (gi = 0; gi < NSTR; gi++) begin : g_rx
      // shift in msb first, park the byte when complete
      always_ff @(posedge clk) begin
        if (srst) begin
          in_sh[gi] <= 8'h00;
          in_buf[gi] <= 8'h00;
        end else if (in_samp) begin
          in_sh[gi] <= {in_sh[gi][6:0], serial_in[gi]};
          if (in_pos[2:0] == 3'h7) begin
            in_buf[gi] <= {in_sh[gi][6:0], serial_in[gi]};
          end
        end
      end
    end
  endgenerate

  // bank flips each frame so constant delay reads a whole frame
  always_ff @(posedge clk) begin
    if (srst) begin
      wbank <= 1'b0;
    end else if (in_fstart) begin
      wbank <= ~wbank;
    end
  end

  // write sequencer, one stream per clock
  wire [2:0] wstr = wcnt[2:0];
  // bank held per burst: the last slot's burst may outlive the bank flip
  wire [8:0] wr_addr = {wr_bank, chan_idx(irate, wstr, wr_ch)};
  always_ff @(posedge clk) begin
    if (srst) begin
      wstate <= SEQ_IDLE;
      wcnt <= 4'h0;
      wr_ch <= 7'h00;
      wr_bank <= 1'b0;
    end else begin
      case (wstate)
        SEQ_IDLE: begin
          if (byte_done) begin
            wstate <= SEQ_RUN;
            wcnt <= 4'h0;
            wr_ch <= in_pos[9:3];
            wr_bank <= wbank;
          end
        end
        default: begin
          if ({1'b0, wstr} < in_n) begin
            data_mem[wr_addr] <= in_buf[wstr];
          end
          wcnt <= wcnt + 4'h1;
          if (wcnt == 4'h7) begin
            wstate <= SEQ_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // transmit: prefetch next slot, then serialise
  logic [7:0] pend_byte [0:NSTR-1];
  logic [7:0] pend_cfg [0:NSTR-1];
  logic [7:0] out_sh [0:NSTR-1];
  logic [NSTR-1:0] chan_en;
  logic [6:0] fch;
  logic [3:0] fcnt;
  tss_seq_t fstate;

  wire slot_start = out_bound & (out_pos[2:0] == 3'h0);
  wire [6:0] ch_mask = (orate == RATE_8M) ? 7'h7f : ((orate == RATE_4M) ? 7'h3f : 7'h1f);
  wire [6:0] next_ch = (out_pos[9:3] + 7'h01) & ch_mask;
  wire [2:0] fstr = fcnt[2:0];
  wire [7:0] cm_idx = chan_idx(orate, fstr, fch);
  wire [7:0] f_low = conn_mem_low[cm_idx];
  wire [7:0] f_high = conn_mem_high[cm_idx];
  wire f_bank = f_high[CMH_CDLY] ? ~wbank : wbank;
  wire [7:0] f_dm = data_mem[{f_bank, f_low}];
  wire [7:0] f_byte = f_high[CMH_MSG] ? f_low : f_dm;

  // fetch sequencer runs during the slot before the one it serves
  always_ff @(posedge clk) begin
    if (srst) begin
      fstate <= SEQ_IDLE;
      fcnt <= 4'h0;
      fch <= 7'h00;
    end else begin
      case (fstate)
        SEQ_IDLE: begin
          if (slot_start) begin
            fstate <= SEQ_RUN;
            fcnt <= 4'h0;
            fch <= next_ch;
          end
        end
        default: begin
          fcnt <= fcnt + 4'h1;
          if (fcnt == 4'h7) begin
            fstate <= SEQ_IDLE;
          end
        end
      endcase
    end
  end

  generate
    for (gi = 0; gi < NSTR; gi++) begin : g_tx
      // capture the fetched byte and its channel controls
      always_ff @(posedge clk) begin
        if (srst) begin
          pend_byte[gi] <= 8'h00;
          pend_cfg[gi] <= CMH_RST;
        end else if (fstate == SEQ_RUN && fstr == gi) begin
          pend_byte[gi] <= f_byte;
          pend_cfg[gi] <= f_high;
        end
      end

      // load at the slot edge, shift msb first
      always_ff @(posedge clk) begin
        if (srst) begin
          out_sh[gi] <= 8'h00;
          serial_out[gi] <= 1'b1;
          chan_en[gi] <= 1'b0;
        end else if (slot_start) begin
          out_sh[gi] <= {pend_byte[gi][6:0], 1'b0};
          serial_out[gi] <= pend_byte[gi][7];
          chan_en[gi] <= pend_cfg[gi][CMH_OE] & (gi < out_n);
        end else if (out_bound) begin
          out_sh[gi] <= {out_sh[gi][6:0], 1'b0};
          serial_out[gi] <= out_sh[gi][7];
        end
      end

      // drive pin low enable when driving
      always_ff @(posedge clk) begin
        if (srst) begin
          serial_out_oe_n[gi] <= 1'b1;
        end else begin
          serial_out_oe_n[gi] <= ~(output_drive_enable & chan_en[gi]);
        end
      end
    end
  endgenerate

  // control serial output, one high memory bit per bit time
  always_ff @(posedge clk) begin
    if (srst) begin
      control_serial_out <= 1'b0;
    end else if (out_bound) begin
      control_serial_out <= conn_mem_high[out_pos[7:0]][CMH_CSO];
    end
  end

  // ==========================================================
  // cpu access: page and memory select from control register
  wire mem_hit = addr[MEM_WIN_BIT];
  wire [1:0] msel = ctrl[CTRL_MSEL_LSB +: 2];
  wire [7:0] cpu_idx = {ctrl[CTRL_PAGE_LSB +: 3], addr[4:0]};
  wire [7:0] dm_rd = data_mem[{wbank, cpu_idx}];
  wire [7:0] stat = {6'h00, tif.pol_pos, tif.fmt_valid};
  wire [7:0] mem_rd = (msel == MSEL_DM) ? dm_rd
                    : (msel == MSEL_CML) ? conn_mem_low[cpu_idx]
                    : (msel == MSEL_CMH) ? conn_mem_high[cpu_idx] : 8'h00;
  wire [7:0] reg_rd = (addr == REG_CTRL) ? ctrl
                    : (addr == REG_IMS) ? interface_mode_select_reg
                    : (addr == REG_STAT) ? stat : 8'h00;

  // register writes
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl <= CTRL_RST;
      interface_mode_select_reg <= IMS_RST;
    end else if (wr && !mem_hit) begin
      if (addr == REG_CTRL) begin
        ctrl <= wdata;
      end else if (addr == REG_IMS) begin
        interface_mode_select_reg <= wdata;
      end
    end
  end

  // connect memory writes
  always_ff @(posedge clk) begin
    if (wr && mem_hit && msel == MSEL_CML) begin
      conn_mem_low[cpu_idx] <= wdata;
    end
    if (wr && mem_hit && msel == MSEL_CMH) begin
      conn_mem_high[cpu_idx] <= wdata;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      rdata <= mem_hit ? mem_rd : reg_rd;
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule : tss_core

/* bench/tss_core_sva.sv */
`timescale 1ns/1ps
// ==========================================================
// port level checks for the switch core
module tss_core_sva import tss_pkg::*; (
  // system
  input wire logic clk,
  input wire logic srst,
  // link and streams
  input wire logic link_clk,
  input wire logic output_drive_enable,
  input wire logic [NSTR-1:0] serial_out,
  input wire logic [NSTR-1:0] serial_out_oe_n,
  input wire logic control_serial_out,
  // register port
  input wire logic [5:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // cycles since the last seen link clock change
  logic lk_q;
  logic [3:0] since_lk;
  always_ff @(posedge clk) begin
    lk_q <= link_clk;
    if (srst || lk_q != link_clk) begin
      since_lk <= 4'h0;
    end else if (since_lk != 4'hf) begin
      since_lk <= since_lk + 4'h1;
    end
  end
  // ==========================================================
  // assertions
  rd_idle_zero_a: assert property (!rd |=> rdata == 8'h00)
    else $error("read data not zero outside a read");
  unmapped_read_a: assert property (rd && addr == 6'h03 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  ctrl_readback_a: assert property (wr && addr == REG_CTRL ##1 !wr ##1 rd && addr == REG_CTRL
    |=> rdata[4:0] == $past(wdata[4:0], 3)) else $error("control register readback wrong");
  mode_readback_a: assert property (wr && addr == REG_IMS ##1 !wr ##1 rd && addr == REG_IMS
    |=> rdata == $past(wdata, 3)) else $error("mode register readback wrong");
  drive_off_a: assert property (!output_drive_enable [*3] |-> &serial_out_oe_n)
    else $error("outputs driven with drive enable low");
  bit_hold_a: assert property ($changed(serial_out) |=> $stable(serial_out) [*4])
    else $error("serial outputs changed inside a bit");
  out_edge_a: assert property ($changed(serial_out) |-> since_lk <= 4'h3)
    else $error("serial output changed away from a link edge");
  ctl_edge_a: assert property ($changed(control_serial_out) |-> since_lk <= 4'h3)
    else $error("control output changed away from a link edge");
  // main scenarios
  cover property (rd && addr[5]);
  cover property ($fell(output_drive_enable));
  cover property ($changed(control_serial_out));
endmodule : tss_core_sva

bind tss_core tss_core_sva i_tss_core_sva (.clk(clk), .srst(srst), .link_clk(link_clk),
  .output_drive_enable(output_drive_enable), .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n),
  .control_serial_out(control_serial_out), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));

/* bench/tss_tdm_far.sv */
`timescale 1ns/1ps
// ==========================================================
// far side: native 2 Mb/s streams, link clock, output capture
module tss_tdm_far import tss_pkg::*; (
  // system
  input wire logic clk,
  // link out
  output logic link_clk,
  output logic frame_pulse,
  output logic [NSTR-1:0] serial_in,
  // streams from the core
  input wire logic [NSTR-1:0] serial_out,
  input wire logic [NSTR-1:0] serial_out_oe_n,
  input wire logic control_serial_out
);
  logic [3:0] t = 4'h0;
  logic [8:0] lc = 9'h000;
  int frames = 0;
  logic [7:0] sh [NSTR];
  logic [7:0] rx_byte [NSTR][CH_LOW];
  logic rx_oe [NSTR][CH_LOW];
  logic cso_bit [256];
  // a released line shows the inverse of the level serial_out still shifts out
  wire [NSTR-1:0] line = serial_out ^ serial_out_oe_n;
  // link clock near 4.096 MHz, twice the bit rate, falls at t 0
  assign link_clk = (t >= 4'h6);
  // short low pulse across the falling edge that opens the frame
  assign frame_pulse = !((lc == 9'h1ff && t >= 4'h3) || (lc == 9'h000 && t < 4'h3));
  // 32 channels, msb first, new bit every second falling edge
  always_comb begin
    for (int s = 0; s < NSTR; s++) begin
      serial_in[s] = 1'(({3'(s), lc[8:4]} ^ 8'ha5) >> (3'h7 - lc[3:1]));
    end
  end
  // link timing and capture at the late rising edge of each bit
  always @(posedge clk) begin
    t <= (t == 4'hb) ? 4'h0 : t + 4'h1;
    if (t == 4'hb) begin
      lc <= lc + 9'h001;
      if (lc == 9'h1ff) begin
        frames <= frames + 1;
      end
    end
    if (lc[0] && t == 4'h8) begin
      for (int s = 0; s < NSTR; s++) begin
        sh[s] <= {sh[s][6:0], line[s]};
        if (lc[3:1] == 3'h7) begin
          rx_byte[s][lc[8:4]] <= {sh[s][6:0], line[s]};
          rx_oe[s][lc[8:4]] <= serial_out_oe_n[s];
        end
      end
      cso_bit[lc[8:1]] <= control_serial_out;
    end
  end
endmodule : tss_tdm_far

/* bench/testbench.sv */
`timescale 1ns/1ps
// ==========================================================
// self-checking bench for the switch core
module testbench import tss_pkg::*;;
  `define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("ERROR %0t: got %h expected %h", $time, g, e); end end
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic output_drive_enable = 1'b1;
  logic [5:0] addr = 6'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic link_clk, frame_pulse, control_serial_out;
  logic [NSTR-1:0] serial_in, serial_out, serial_out_oe_n;
  logic [7:0] rdata;
  logic [7:0] got;
  int n_mismatch = 0;
  int checks = 0;
  // ==========================================================
  // design and far side
  tss_core i_tss_core (.clk(clk), .srst(srst), .link_clk(link_clk), .frame_pulse(frame_pulse),
    .output_drive_enable(output_drive_enable), .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n), .control_serial_out(control_serial_out), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  tss_tdm_far i_tss_tdm_far (.clk(clk), .link_clk(link_clk), .frame_pulse(frame_pulse),
    .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n),
    .control_serial_out(control_serial_out));
  initial begin
    forever #10 clk = ~clk;
  end
  // ==========================================================
  // register port tasks
  task automatic bus_wr(input logic [5:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : bus_wr
  task automatic bus_rd(input logic [5:0] a, output logic [7:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge clk);
  endtask : bus_rd
  // page and memory select go through the control register
  task automatic mem_wr(input logic [1:0] sel, input logic [7:0] idx, input logic [7:0] d);
    bus_wr(REG_CTRL, {3'h0, idx[7:5], sel});
    bus_wr({1'b1, idx[4:0]}, d);
  endtask : mem_wr
  task automatic wait_frames(input int n);
    int stop;
    stop = i_tss_tdm_far.frames + n;
    for (int k = 0; k < 6200 * n && i_tss_tdm_far.frames < stop; k++) @(posedge clk);
    if (i_tss_tdm_far.frames < stop) begin
      n_mismatch++;
      $display("ERROR %0t: frame wait timed out", $time);
      results();
    end
  endtask : wait_frames
  task automatic results;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results
  // low connect content: permuted, broadcast, message, identity
  function automatic logic [7:0] low_of(input int s, input int c);
    case (s)
      0: return {3'h1, 5'(31 - c)};
      1: return {3'h2, 5'h05};
      2: return 8'(c) ^ 8'h3c;
      default: return {3'(s), 5'(c)};
    endcase
  endfunction : low_of
  // high connect content: enable, message, constant delay, control bit
  function automatic logic [7:0] high_of(input int s, input int c);
    case (s)
      2: return 8'h03;
      3: return c[0] ? 8'h00 : 8'h01;
      4: return 8'h05;
      5: return 8'h09;
      default: return 8'h01;
    endcase
  endfunction : high_of
  // ==========================================================
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    bus_rd(REG_CTRL, got); `CHK(got, CTRL_RST)
    bus_rd(REG_IMS, got); `CHK(got, IMS_RST)
    bus_rd(6'h03, got); `CHK(got, 8'h00)
    bus_wr(REG_IMS, 8'h9e);
    bus_rd(REG_IMS, got); `CHK(got, 8'h9e)
    bus_wr(REG_IMS, 8'h00);
    for (int s = 0; s < NSTR; s++) begin
      for (int c = 0; c < CH_LOW; c++) begin
        mem_wr(MSEL_CML, {3'(s), 5'(c)}, low_of(s, c));
        mem_wr(MSEL_CMH, {3'(s), 5'(c)}, high_of(s, c));
      end
    end
    bus_wr(REG_CTRL, 8'h1d);
    bus_rd(REG_CTRL, got); `CHK(got, 8'h1d)
    bus_rd(6'h27, got); `CHK(got, 8'he7)
    got = 8'h00;
    for (int k = 0; k < 8000 && got[0] !== 1'b1; k++) bus_rd(REG_STAT, got);
    `CHK(got[1:0], 2'b01)
    if (got[0] !== 1'b1) results();
    wait_frames(4);
    // every output slot: data, source sharing, message, float
    for (int s = 0; s < NSTR; s++) begin
      for (int c = 0; c < CH_LOW; c++) begin
        got = ((s == 2) ? low_of(s, c) : low_of(s, c) ^ 8'ha5) ^ {8{s == 3 && c % 2 == 1}};
        `CHK(i_tss_tdm_far.rx_byte[s][c], got)
        `CHK(i_tss_tdm_far.rx_oe[s][c], 1'(s == 3 && c % 2 == 1))
      end
    end
    for (int k = 0; k < 256; k++) begin
      `CHK(i_tss_tdm_far.cso_bit[k], 1'(k / 32 == 5))
    end
    // message byte replaced, neighbour untouched
    mem_wr(MSEL_CML, 8'h40, 8'h77);
    wait_frames(2);
    `CHK(i_tss_tdm_far.rx_byte[2][0], 8'h77)
    `CHK(i_tss_tdm_far.rx_byte[2][1], low_of(2, 1))
    // drive enable low floats every slot
    output_drive_enable <= 1'b0;
    wait_frames(2);
    for (int s = 0; s < NSTR; s++) begin
      for (int c = 0; c < CH_LOW; c++) begin
        `CHK(i_tss_tdm_far.rx_oe[s][c], 1'b1)
      end
    end
    results();
  end
endmodule : testbench
